// file: hdl/frt_pkg.sv
// Constants for the fault record tracking data block.
// Assumes one 250 MHz clock domain; bytes travel least significant first.
package frt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Record layout
    localparam int FRT_FIELD_BYTES = 10;
    localparam int FRT_TRK_BYTES = 40;
    localparam int FRT_CNT_BYTES = 7;
    localparam int FRT_EVT_BYTES = 38;
    localparam int FRT_PRESENT_OFS = 40;
    localparam int FRT_EVT_OFS = 47;
    localparam int FRT_REC_USED = 85;
    localparam logic [7:0] FRT_REC_BYTES = 8'hED;
    localparam logic [7:0] FRT_RAM_BASE = 8'h00;
    localparam logic [7:0] FRT_NV_BASE = 8'h40;
    localparam int FRT_MEM_DEPTH = 256;

    // Event slot field positions
    localparam int FRT_EVT_ONT = 0;
    localparam int FRT_EVT_RTC = 3;
    localparam int FRT_EVT_AC = 7;
    localparam int FRT_EVT_SUPPLY_ON_REQUEST_N = 9;
    localparam int FRT_EVT_END = 11;

    // Counter widths and limits
    localparam int FRT_ONT_W = 24;
    localparam int FRT_CYC_W = 16;
    localparam logic [15:0] FRT_CYC_MAX = 16'hFFFF;
    localparam logic [23:0] FRT_ONT_MAX = 24'hFFFFFF;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam longint FRT_CLK_HZ = 250_000_000;
    localparam longint FRT_MINUTE_S = 60;
    localparam longint FRT_MINUTE_CYCLES = FRT_MINUTE_S * FRT_CLK_HZ;
    localparam int FRT_PRE_W = 34;

    // Packet error check
    localparam logic [7:0] FRT_PEC_POLY = 8'h07;
    localparam logic [7:0] FRT_PEC_INIT = 8'h00;

    typedef enum logic [7:0] {
        FRT_IDLE = 8'h01,
        FRT_TRK_SAVE = 8'h02,
        FRT_EVT_SAVE = 8'h04,
        FRT_RD_CNT = 8'h08,
        FRT_RD_FETCH = 8'h10,
        FRT_RD_LOAD = 8'h20,
        FRT_RD_SEND = 8'h40,
        FRT_RD_PEC = 8'h80
    } frt_state_e;

endpackage

// file: hdl/frt_mem.sv
// Byte memory holding host tracking RAM and the recorder image.
// Assumes one write and one read per cycle; read data one cycle later.
module frt_mem
    import frt_pkg::*;
#(
    parameter int DEPTH = FRT_MEM_DEPTH,
    parameter int AW = 8
) (
    input wire logic i_clk,
    input wire logic i_ce,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem_r [DEPTH];

    ////////////////////////////////////////////////////////////////////////////
    // Storage and registered read
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            if (i_we) begin
                mem_r[i_waddr] <= i_wdata;
            end
            o_rdata <= mem_r[i_raddr];
        end
    end
endmodule

// file: hdl/frt_tracking.sv
// Tracking section of a supply fault recorder: counters, saves, readout.
// Assumes an SMBus engine outside that frames the stream and seeds the PEC.
module frt_tracking
    import frt_pkg::*;
#(
    parameter longint MINUTE_CYCLES = FRT_MINUTE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_supply_on_request_n,
    input wire logic i_mains_ok,
    input wire logic i_sys_event,
    input wire logic i_fault_shutdown,
    input wire logic i_trk_wr_en,
    input wire logic [5:0] i_trk_wr_addr,
    input wire logic [7:0] i_trk_wr_data,
    output logic o_trk_wr_ready,
    input wire logic i_fault_record_read,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    output logic o_rd_last,
    input wire logic i_rd_ready,
    input wire logic [7:0] i_pec_seed,
    output logic o_busy,
    output logic [23:0] o_on_time,
    output logic [15:0] o_ac_cycles,
    output logic [15:0] o_supply_on_request_n_cycles
);
    localparam logic [FRT_PRE_W-1:0] PRE_LAST = FRT_PRE_W'(MINUTE_CYCLES - 1);

    function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] din);
        logic [7:0] c;
        c = crc ^ din;
        for (int b = 0; b < 8; b++) begin
            c = c[7] ? ((c << 1) ^ FRT_PEC_POLY) : (c << 1);
        end
        return c;
    endfunction

    function automatic logic [7:0] cnt_byte(input int idx, input logic [23:0] ont,
                                            input logic [15:0] ac, input logic [15:0] ps);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            0: b = ont[7:0];
            1: b = ont[15:8];
            2: b = ont[23:16];
            3: b = ac[7:0];
            4: b = ac[15:8];
            5: b = ps[7:0];
            6: b = ps[15:8];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, three stages, change taken when last two agree
    logic [2:0] son_sync_r;
    logic [2:0] mains_sync_r;
    logic son_r, son_nxt;
    logic mains_r, mains_nxt;

    always_comb begin
        son_nxt = (son_sync_r[1] == son_sync_r[2]) ? ~son_sync_r[2] : son_r;
        mains_nxt = (mains_sync_r[1] == mains_sync_r[2]) ? mains_sync_r[2] : mains_r;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            son_sync_r <= 3'h7;
            mains_sync_r <= 3'h0;
            son_r <= 1'b0;
            mains_r <= 1'b0;
        end else if (i_ce) begin
            son_sync_r <= {son_sync_r[1:0], i_supply_on_request_n};
            mains_sync_r <= {mains_sync_r[1:0], i_mains_ok};
            son_r <= son_nxt;
            mains_r <= mains_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Volatile counters
    logic [FRT_PRE_W-1:0] pre_r, pre_nxt;
    logic [23:0] ont_r, ont_nxt;
    logic [15:0] ac_r, ac_nxt;
    logic [15:0] ps_r, ps_nxt;

    always_comb begin
        pre_nxt = pre_r;
        ont_nxt = ont_r;
        ac_nxt = ac_r;
        ps_nxt = ps_r;
        if (son_r) begin
            if (pre_r == PRE_LAST) begin
                pre_nxt = '0;
                if (ont_r != FRT_ONT_MAX) begin
                    ont_nxt = ont_r + 24'h000001;
                end
            end else begin
                pre_nxt = pre_r + FRT_PRE_W'(1);
            end
        end
        if (mains_nxt && !mains_r && son_r && ac_r != FRT_CYC_MAX) begin
            ac_nxt = ac_r + 16'h0001;
        end
        if (son_nxt && !son_r && mains_r && ps_r != FRT_CYC_MAX) begin
            ps_nxt = ps_r + 16'h0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pre_r <= '0;
            ont_r <= 24'h000000;
            ac_r <= 16'h0000;
            ps_r <= 16'h0000;
        end else if (i_ce) begin
            pre_r <= pre_nxt;
            ont_r <= ont_nxt;
            ac_r <= ac_nxt;
            ps_r <= ps_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: saves and readout
    frt_state_e st_r, st_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic cp_vld_r, cp_vld_nxt;
    logic [7:0] cp_idx_r, cp_idx_nxt;
    logic pend_trk_r, pend_trk_nxt;
    logic pend_evt_r, pend_evt_nxt;
    logic [23:0] snap_ont_r, snap_ont_nxt;
    logic [15:0] snap_ac_r, snap_ac_nxt;
    logic [15:0] snap_ps_r, snap_ps_nxt;
    logic [7:0] data_r, data_nxt;
    logic [7:0] pec_r, pec_nxt;
    logic take_trk, take_evt;
    logic we;
    logic [7:0] waddr, wdata, raddr, rdata;
    int ii;

    always_comb begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        cp_vld_nxt = 1'b0;
        cp_idx_nxt = idx_r;
        snap_ont_nxt = snap_ont_r;
        snap_ac_nxt = snap_ac_r;
        snap_ps_nxt = snap_ps_r;
        data_nxt = data_r;
        pec_nxt = pec_r;
        take_trk = 1'b0;
        take_evt = 1'b0;
        we = 1'b0;
        waddr = FRT_RAM_BASE;
        wdata = 8'h00;
        raddr = idx_r;
        ii = int'(idx_r);
        if (cp_vld_r) begin
            we = 1'b1;
            waddr = FRT_NV_BASE + cp_idx_r;
            wdata = rdata;
        end
        case (st_r)
            FRT_IDLE: begin
                if (i_trk_wr_en && i_trk_wr_addr < 6'(FRT_TRK_BYTES)) begin
                    we = 1'b1;
                    waddr = FRT_RAM_BASE + {2'b00, i_trk_wr_addr};
                    wdata = i_trk_wr_data;
                end
                idx_nxt = 8'h00;
                if (pend_evt_r) begin
                    take_evt = 1'b1;
                    snap_ont_nxt = ont_r;
                    snap_ac_nxt = ac_r;
                    snap_ps_nxt = ps_r;
                    st_nxt = FRT_EVT_SAVE;
                end else if (pend_trk_r) begin
                    take_trk = 1'b1;
                    st_nxt = FRT_TRK_SAVE;
                end else if (i_fault_record_read) begin
                    data_nxt = FRT_REC_BYTES;
                    pec_nxt = i_pec_seed;
                    st_nxt = FRT_RD_CNT;
                end
            end
            FRT_TRK_SAVE: begin
                raddr = FRT_RAM_BASE + idx_r;
                if (ii < FRT_TRK_BYTES) begin
                    cp_vld_nxt = 1'b1;
                    idx_nxt = idx_r + 8'h01;
                end else if (!cp_vld_r) begin
                    st_nxt = FRT_IDLE;
                end
            end
            FRT_EVT_SAVE: begin
                we = 1'b1;
                waddr = FRT_NV_BASE + 8'(FRT_EVT_OFS) + idx_r;
                if (ii < FRT_EVT_RTC) begin
                    wdata = cnt_byte(ii, snap_ont_r, snap_ac_r, snap_ps_r);
                end else if (ii >= FRT_EVT_AC && ii < FRT_EVT_END) begin
                    wdata = cnt_byte(ii - FRT_EVT_AC + 3, snap_ont_r, snap_ac_r, snap_ps_r);
                end
                idx_nxt = idx_r + 8'h01;
                if (ii == FRT_EVT_BYTES - 1) begin
                    st_nxt = FRT_IDLE;
                end
            end
            FRT_RD_CNT: begin
                if (i_rd_ready) begin
                    pec_nxt = crc8(pec_r, data_r);
                    st_nxt = FRT_RD_FETCH;
                end
            end
            FRT_RD_FETCH: begin
                raddr = FRT_NV_BASE + idx_r;
                st_nxt = FRT_RD_LOAD;
            end
            FRT_RD_LOAD: begin
                if (ii >= FRT_PRESENT_OFS && ii < FRT_EVT_OFS) begin
                    data_nxt = cnt_byte(ii - FRT_PRESENT_OFS, ont_r, ac_r, ps_r);
                end else if (ii < FRT_REC_USED) begin
                    data_nxt = rdata;
                end else begin
                    data_nxt = 8'h00;
                end
                st_nxt = FRT_RD_SEND;
            end
            FRT_RD_SEND: begin
                if (i_rd_ready) begin
                    pec_nxt = crc8(pec_r, data_r);
                    if (idx_r == FRT_REC_BYTES - 8'h01) begin
                        data_nxt = crc8(pec_r, data_r);
                        st_nxt = FRT_RD_PEC;
                    end else begin
                        idx_nxt = idx_r + 8'h01;
                        st_nxt = FRT_RD_FETCH;
                    end
                end
            end
            FRT_RD_PEC: begin
                if (i_rd_ready) begin
                    st_nxt = FRT_IDLE;
                end
            end
            default: begin
                st_nxt = FRT_IDLE;
            end
        endcase
        pend_trk_nxt = (pend_trk_r && !take_trk) || i_sys_event;
        pend_evt_nxt = (pend_evt_r && !take_evt) || i_fault_shutdown;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_r <= FRT_IDLE;
            idx_r <= 8'h00;
            cp_vld_r <= 1'b0;
            cp_idx_r <= 8'h00;
            pend_trk_r <= 1'b0;
            pend_evt_r <= 1'b0;
            snap_ont_r <= 24'h000000;
            snap_ac_r <= 16'h0000;
            snap_ps_r <= 16'h0000;
            data_r <= 8'h00;
            pec_r <= FRT_PEC_INIT;
        end else if (i_ce) begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            cp_vld_r <= cp_vld_nxt;
            cp_idx_r <= cp_idx_nxt;
            pend_trk_r <= pend_trk_nxt;
            pend_evt_r <= pend_evt_nxt;
            snap_ont_r <= snap_ont_nxt;
            snap_ac_r <= snap_ac_nxt;
            snap_ps_r <= snap_ps_nxt;
            data_r <= data_nxt;
            pec_r <= pec_nxt;
        end
    end

    frt_mem #(
        .DEPTH(FRT_MEM_DEPTH),
        .AW(8)
    ) u_mem (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_we(we),
        .i_waddr(waddr),
        .i_wdata(wdata),
        .i_raddr(raddr),
        .o_rdata(rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_trk_wr_ready = (st_r == FRT_IDLE);
    assign o_rd_valid = (st_r == FRT_RD_CNT) || (st_r == FRT_RD_SEND) || (st_r == FRT_RD_PEC);
    assign o_rd_last = (st_r == FRT_RD_PEC);
    assign o_rd_data = data_r;
    assign o_busy = (st_r != FRT_IDLE);
    assign o_on_time = ont_r;
    assign o_ac_cycles = ac_r;
    assign o_supply_on_request_n_cycles = ps_r;
endmodule

// file: verification/frt_tracking_props.sv
// Checker for the tracking block: counters, stream framing, idle state.
// Assumes only the block's top ports, one clock, enable low only outside readout.
module frt_tracking_props
    import frt_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_supply_on_request_n,
    input wire logic i_mains_ok,
    input wire logic i_rd_ready,
    input wire logic o_trk_wr_ready,
    input wire logic o_rd_valid,
    input wire logic [7:0] o_rd_data,
    input wire logic o_rd_last,
    input wire logic o_busy,
    input wire logic [23:0] o_on_time,
    input wire logic [15:0] o_ac_cycles,
    input wire logic [15:0] o_supply_on_request_n_cycles
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    ////////////////////////////////////////
    // Counters
    ont_step_a: assert property ($changed(o_on_time) && !$past(i_srst)
        |-> o_on_time == $past(o_on_time) + 24'h000001) else $error("on-time step wrong");
    ac_step_a: assert property ($changed(o_ac_cycles) && !$past(i_srst)
        |-> o_ac_cycles == $past(o_ac_cycles) + 16'h0001) else $error("mains count step wrong");
    ps_step_a: assert property ($changed(o_supply_on_request_n_cycles) && !$past(i_srst)
        |-> o_supply_on_request_n_cycles == $past(o_supply_on_request_n_cycles) + 16'h0001) else $error("request step wrong");
    ont_gate_a: assert property (i_supply_on_request_n [*6] |=> $stable(o_on_time))
        else $error("on-time moved while not requested");
    ac_gate_a: assert property (i_supply_on_request_n [*6] |=> $stable(o_ac_cycles))
        else $error("mains count moved while not requested");
    ps_gate_a: assert property (!i_mains_ok [*6] |=> $stable(o_supply_on_request_n_cycles))
        else $error("request count moved without mains");
    ////////////////////////////////////////
    // Readout stream
    rd_count_a: assert property ($rose(o_rd_valid) && $past(o_trk_wr_ready)
        |-> o_rd_data == FRT_REC_BYTES) else $error("first byte not the count");
    rd_hold_a: assert property (o_rd_valid && !i_rd_ready
        |=> o_rd_valid && $stable(o_rd_data) && $stable(o_rd_last)) else $error("byte dropped");
    rd_end_a: assert property (o_rd_valid && o_rd_last && i_rd_ready
        |=> o_trk_wr_ready && !o_rd_valid) else $error("no idle after check byte");
    save_quiet_a: assert property ($rose(o_busy) && !o_rd_valid |=> !o_rd_valid [*8])
        else $error("stream byte during save");
    cover property (o_rd_valid && o_rd_last && i_rd_ready);
    cover property ($rose(o_busy));
    cover property ($changed(o_ac_cycles) && !$past(i_srst));
endmodule

bind frt_tracking frt_tracking_props i_props (
    .i_clk, .i_srst, .i_supply_on_request_n, .i_mains_ok, .i_rd_ready, .o_trk_wr_ready,
    .o_rd_valid, .o_rd_data, .o_rd_last, .o_busy, .o_on_time, .o_ac_cycles, .o_supply_on_request_n_cycles
);

// file: verification/frt_host_model.sv
// Host side of the readout stream: takes bytes, stalls from an LFSR.
// Assumes the bench owns reset; each taken byte shows one cycle later.
module frt_host_model (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_stall_en,
    input wire logic i_valid,
    input wire logic [7:0] i_data,
    input wire logic i_last,
    output logic o_ready,
    output logic o_got,
    output logic [7:0] o_byte,
    output logic o_got_last
);
    logic [7:0] lfsr_r;
    logic [7:0] lfsr_nxt;
    logic take;
    always_comb begin
        lfsr_nxt = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        o_ready = ~(i_stall_en & lfsr_r[0]);
        take = i_valid & o_ready;
    end
    always_ff @(posedge i_clk) begin
        lfsr_r <= i_srst ? 8'h5A : lfsr_nxt;
        o_got <= ~i_srst & take;
        o_byte <= i_data;
        o_got_last <= ~i_srst & take & i_last;
    end
endmodule

// file: verification/frt_tracking_tb_top.sv
// Testbench: random counter traffic, tracking writes, saves, readout.
// Assumes a 20-cycle minute and a stalling host model on the stream.
module frt_tracking_tb_top
    import frt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_ce = 1'b1;
    logic req_n = 1'b1;
    logic mains = 1'b0;
    logic sys_ev = 1'b0;
    logic flt = 1'b0;
    logic wr_en = 1'b0;
    logic [5:0] wr_addr = 6'h00;
    logic [7:0] wr_data = 8'h00;
    logic rd = 1'b0;
    logic [7:0] seed = 8'h00;
    logic wr_rdy, vld, last, rdy, busy, got, got_last;
    logic [7:0] rdata, got_byte;
    logic [23:0] ont;
    logic [15:0] acc, psc;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int req_cyc = 0;
    int exp_ac = 0;
    int exp_ps = 0;
    logic [7:0] rx_q[$];
    logic [7:0] trk[0:39];
    logic [7:0] exp_b[0:238];

    frt_tracking #(.MINUTE_CYCLES(20)) i_frt_tracking (
        .i_clk, .i_srst, .i_ce, .i_supply_on_request_n(req_n), .i_mains_ok(mains),
        .i_sys_event(sys_ev), .i_fault_shutdown(flt), .i_trk_wr_en(wr_en),
        .i_trk_wr_addr(wr_addr), .i_trk_wr_data(wr_data), .o_trk_wr_ready(wr_rdy),
        .i_fault_record_read(rd), .o_rd_valid(vld), .o_rd_data(rdata), .o_rd_last(last),
        .i_rd_ready(rdy), .i_pec_seed(seed), .o_busy(busy), .o_on_time(ont),
        .o_ac_cycles(acc), .o_supply_on_request_n_cycles(psc)
    );
    frt_host_model i_frt_host_model (
        .i_clk, .i_srst, .i_stall_en(1'b1), .i_valid(vld), .i_data(rdata), .i_last(last),
        .o_ready(rdy), .o_got(got), .o_byte(got_byte), .o_got_last(got_last)
    );

    ////////////////////////////////////////
    // Clock, bookkeeping, timeout
    always #2 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (req_n === 1'b0 && i_ce === 1'b1) req_cyc <= req_cyc + 1;
        if (got) rx_q.push_back(got_byte);
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            complete_run();
        end
    end

    task automatic check_byte(input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic check_word(input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int k = 0; k < 8; k++) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
        return r;
    endfunction
    task automatic complete_run();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial begin
        int w;
        logic [7:0] c;
        logic [23:0] ont_hold;
        void'($urandom(32'h6BA9));
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk) mains <= 1'b1;
        repeat (8) @(posedge i_clk);
        req_n <= 1'b0;
        exp_ps++;
        repeat (59) @(posedge i_clk);
        req_n <= 1'b1;
        repeat (8) @(posedge i_clk);
        #1 check_word(24'h000002, ont);
        check_word(24'h000000, {8'h00, acc});
        req_n <= 1'b0;
        exp_ps++;
        repeat (10) @(posedge i_clk);
        i_ce <= 1'b0;
        @(posedge i_clk);
        #1 ont_hold = ont;
        repeat (30) @(posedge i_clk);
        #1 check_word(ont_hold, ont);
        @(posedge i_clk) i_ce <= 1'b1;
        repeat (16) begin
            w = 8 + ($urandom % 32);
            @(posedge i_clk);
            if ($urandom % 2) begin
                if (!mains && !req_n) exp_ac++;
                mains <= ~mains;
            end else begin
                if (req_n && mains) exp_ps++;
                req_n <= ~req_n;
            end
            repeat (w) @(posedge i_clk);
        end
        @(posedge i_clk) req_n <= 1'b1;
        repeat (8) @(posedge i_clk);
        #1 check_word(24'(req_cyc / 20), ont);
        check_word(24'(exp_ac), {8'h00, acc});
        check_word(24'(exp_ps), {8'h00, psc});
        for (int a = 0; a < 40; a++) begin
            trk[a] = 8'h20 + 8'($urandom % 95);
            @(posedge i_clk);
            wr_en <= 1'b1;
            wr_addr <= 6'(a);
            wr_data <= trk[a];
        end
        @(posedge i_clk);
        wr_addr <= 6'(40 + $urandom % 24);
        @(posedge i_clk);
        wr_en <= 1'b0;
        flt <= 1'b1;
        sys_ev <= 1'b1;
        @(posedge i_clk);
        flt <= 1'b0;
        sys_ev <= 1'b0;
        rd <= 1'b1;
        seed <= 8'($urandom);
        repeat (4) @(posedge i_clk);
        wr_en <= 1'b1;
        wr_addr <= 6'h00;
        wr_data <= ~trk[0];
        @(posedge i_clk);
        wr_en <= 1'b0;
        #1 check_word(24'h000001, {23'h0, busy});
        w = 0;
        while (rx_q.size() == 0 && w < 400) begin
            @(posedge i_clk);
            w++;
        end
        rd <= 1'b0;
        while (!got_last && w < 3000) begin
            @(posedge i_clk);
            w++;
        end
        repeat (2) @(posedge i_clk);
        foreach (exp_b[k]) exp_b[k] = 8'h00;
        exp_b[0] = FRT_REC_BYTES;
        for (int a = 0; a < 40; a++) exp_b[1 + a] = trk[a];
        {exp_b[43], exp_b[42], exp_b[41]} = 24'(req_cyc / 20);
        {exp_b[45], exp_b[44]} = 16'(exp_ac);
        {exp_b[47], exp_b[46]} = 16'(exp_ps);
        for (int a = 0; a < 3; a++) exp_b[48 + a] = exp_b[41 + a];
        for (int a = 0; a < 4; a++) exp_b[55 + a] = exp_b[44 + a];
        c = seed;
        for (int k = 0; k < 238; k++) c = crc_step(c, exp_b[k]);
        exp_b[238] = c;
        check_word(24'd239, 24'(rx_q.size()));
        for (int k = 0; k < 239; k++) check_byte(exp_b[k], rx_q[k]);
        complete_run();
    end
endmodule
